//--- src/aux_pin_regs.sv
// pin data/direction and auxiliary converter configuration registers on ahb-lite
//
// Decided for this implementation: the AHB-Lite register port.
`timescale 1ns/1ps
module aux_pin_regs
  import aux_regs_pkg::*;
#(
  parameter int unsigned CNT_10  = DIV_10,
  parameter int unsigned CNT_100 = DIV_100,
  parameter int unsigned CNT_400 = DIV_400,
  parameter int unsigned CNT_800 = DIV_800
) (
  // clock and reset
  input  wire logic                 CLK,
  input  wire logic                 RESETN,
  // ahb-lite slave
  input  wire logic                 HSEL,
  input  wire logic [BUS_W-1:0]     HADDR,
  input  wire logic [1:0]           HTRANS,
  input  wire logic                 HWRITE,
  input  wire logic [2:0]           HSIZE,
  input  wire logic [BUS_W-1:0]     HWDATA,
  input  wire logic                 HREADY,
  output logic                      HREADYOUT,
  output logic [BUS_W-1:0]          HRDATA,
  output logic                      HRESP,
  // general-purpose pins
  input  wire logic [NUM_PINS-1:0]  PIN_IN,
  output logic [NUM_PINS-1:0]       PIN_OUT,
  output logic [NUM_PINS-1:0]       PIN_OE,
  // auxiliary converter controls
  output aux_regs_pkg::aux_cfg_s    AUX_CFG,
  output aux_regs_pkg::aux_mux_s    AUX_INPUT_SEL,
  output logic [REG_W-1:0]          AUX_GAIN_FACTOR,
  output logic                      AUX_REF_RESERVED,
  output logic                      AUX_SAMPLE_TICK
);

  import aux_regs_pkg::*;

  // data-phase tracker
  typedef enum logic [2:0] {
    PH_IDLE  = 3'b001,
    PH_WRITE = 3'b010,
    PH_READ  = 3'b100
  } phase_e;

  phase_e                phase_ff;
  phase_e                nxt_phase;
  logic [IDX_W-1:0]      idx_ff;
  logic [IDX_W-1:0]      nxt_idx;
  logic                  addr_ok_ff;
  logic                  nxt_addr_ok;
  logic                  take;
  logic [IDX_W-1:0]      addr_idx;
  logic                  addr_ok;

  // register state
  logic [NUM_PINS-1:0]   pin_dir_ff;
  logic [NUM_PINS-1:0]   nxt_pin_dir;
  logic [NUM_PINS-1:0]   pin_level_bits_ff;
  logic [NUM_PINS-1:0]   nxt_pin_level_bits;
  aux_cfg_s              aux_cfg_ff;
  aux_cfg_s              nxt_aux_cfg;
  aux_mux_s              aux_mux_ff;
  aux_mux_s              nxt_aux_mux;

  // derived outputs
  logic [NUM_PINS-1:0]   pin_out_ff;
  logic [NUM_PINS-1:0]   pin_oe_ff;
  logic [NUM_PINS-1:0]   nxt_pin_out;
  logic [NUM_PINS-1:0]   nxt_pin_oe;
  logic [REG_W-1:0]      gain_factor_ff;
  logic [REG_W-1:0]      nxt_gain_factor;
  logic                  ref_rsvd_ff;
  logic                  nxt_ref_rsvd;
  logic [REG_W-1:0]      stat_value;

  // bus answer
  logic [BUS_W-1:0]      rdata_ff;
  logic [BUS_W-1:0]      nxt_rdata;
  logic                  readyout_ff;
  logic                  nxt_readyout;
  logic                  resp_ff;
  logic                  nxt_resp;

  // pin sampling
  logic [NUM_PINS-1:0]   pin_sync;
  logic [NUM_PINS-1:0]   pin_read_bits;

  // ---------------------------------------------------------------
  // address phase decode
  // ---------------------------------------------------------------
  // size is not decoded; every access acts as a whole word
  assign take     = HSEL && (HTRANS == HTRANS_NONSEQ) && HREADY;
  assign addr_idx = HADDR[IDX_LSB +: IDX_W];

  always_comb begin
    addr_ok = 1'b0;
    // anything outside the aligned low window is unmapped
    if ((HADDR[IDX_LSB-1:0] == '0) && (HADDR[BUS_W-1:IDX_LSB+IDX_W] == '0)) begin
      unique case (addr_idx)
        IDX_PIN_DIR, IDX_PIN_DATA, IDX_AUX_CFG, IDX_AUX_MUX, IDX_AUX_STAT: begin
          addr_ok = 1'b1;
        end
        default: begin
          addr_ok = 1'b0;
        end
      endcase
    end
  end

  // the slave never stalls, so a data phase lasts exactly one cycle
  always_comb begin
    nxt_phase   = PH_IDLE;
    nxt_idx     = idx_ff;
    nxt_addr_ok = addr_ok_ff;
    if (take) begin
      nxt_phase   = HWRITE ? PH_WRITE : PH_READ;
      nxt_idx     = addr_idx;
      nxt_addr_ok = addr_ok;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      phase_ff   <= PH_IDLE;
      idx_ff     <= '0;
      addr_ok_ff <= 1'b0;
    end else begin
      phase_ff   <= nxt_phase;
      idx_ff     <= nxt_idx;
      addr_ok_ff <= nxt_addr_ok;
    end
  end

  // ---------------------------------------------------------------
  // register writes, applied in the data phase
  // ---------------------------------------------------------------
  always_comb begin
    nxt_pin_dir        = pin_dir_ff;
    nxt_pin_level_bits = pin_level_bits_ff;
    nxt_aux_cfg        = aux_cfg_ff;
    nxt_aux_mux        = aux_mux_ff;
    if ((phase_ff == PH_WRITE) && addr_ok_ff) begin
      unique case (idx_ff)
        IDX_PIN_DIR: begin
          nxt_pin_dir = HWDATA[NUM_PINS-1:0];
        end
        IDX_PIN_DATA: begin
          // stored for every bit; input bits still reach PIN_OUT, but their PIN_OE bit is off
          nxt_pin_level_bits = HWDATA[NUM_PINS-1:0];
        end
        IDX_AUX_CFG: begin
          nxt_aux_cfg = aux_cfg_s'(HWDATA[REG_W-1:0]);
        end
        IDX_AUX_MUX: begin
          nxt_aux_mux = aux_mux_s'(HWDATA[REG_W-1:0]);
        end
        default: begin
          // status is read-only; write has no effect
        end
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      pin_dir_ff        <= RST_PIN_DIR;
      pin_level_bits_ff <= RST_PIN_DATA;
      aux_cfg_ff        <= aux_cfg_s'(RST_AUX_CFG);
      aux_mux_ff        <= aux_mux_s'(RST_AUX_MUX);
    end else begin
      pin_dir_ff        <= nxt_pin_dir;
      pin_level_bits_ff <= nxt_pin_level_bits;
      aux_cfg_ff        <= nxt_aux_cfg;
      aux_mux_ff        <= nxt_aux_mux;
    end
  end

  // ---------------------------------------------------------------
  // pins
  // ---------------------------------------------------------------
  // input pin reads lag the pin by the two synchroniser edges
  pin_level_sync #(
    .WIDTH    (NUM_PINS)
  ) u_pin_sync (
    .clk      (CLK),
    .resetn   (RESETN),
    .async_in (PIN_IN),
    .sync_out (pin_sync)
  );

  genvar n;
  generate
    for (n = 0; n < NUM_PINS; n++) begin : g_pin
      // output pins report the stored bit, input pins the sampled level
      assign pin_read_bits[n] = (nxt_pin_dir[n] == DIR_INPUT) ? pin_sync[n]
                                                              : nxt_pin_level_bits[n];
    end
  endgenerate

  // built from next values so pin and register change on the same edge
  always_comb begin
    nxt_pin_out = nxt_pin_level_bits;
    nxt_pin_oe  = ~nxt_pin_dir;
  end

  // drivers stay off in reset; they turn on one edge after release
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      pin_out_ff <= '0;
      pin_oe_ff  <= '0;
    end else begin
      pin_out_ff <= nxt_pin_out;
      pin_oe_ff  <= nxt_pin_oe;
    end
  end

  // ---------------------------------------------------------------
  // auxiliary converter decode
  // ---------------------------------------------------------------
  always_comb begin
    nxt_gain_factor = REG_W'(1) << nxt_aux_cfg.gain;
    // reserved codes are flagged; downstream behaviour is left open
    nxt_ref_rsvd    = (nxt_aux_cfg.ref_sel > REF_SUPPLY);
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      gain_factor_ff <= REG_W'(1);
      ref_rsvd_ff    <= 1'b0;
    end else begin
      gain_factor_ff <= nxt_gain_factor;
      ref_rsvd_ff    <= nxt_ref_rsvd;
    end
  end

  // rate follows the stored register, one edge after the write lands
  aux_rate_timer #(
    .CNT_10  (CNT_10),
    .CNT_100 (CNT_100),
    .CNT_400 (CNT_400),
    .CNT_800 (CNT_800)
  ) u_rate (
    .clk     (CLK),
    .resetn  (RESETN),
    .rate    (aux_cfg_ff.rate),
    .tick    (AUX_SAMPLE_TICK)
  );

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  // read-only summary of the reference flag and the input-select classes
  always_comb begin
    stat_value                  = '0;
    stat_value[STAT_REF_RSVD]   = nxt_ref_rsvd;
    stat_value[STAT_POS_COMMON] = (nxt_aux_mux.pos == MUX_COMMON);
    stat_value[STAT_NEG_COMMON] = (nxt_aux_mux.neg == MUX_COMMON);
    stat_value[STAT_POS_AIN]    = (nxt_aux_mux.pos <= MUX_LAST_AIN);
    stat_value[STAT_NEG_AIN]    = (nxt_aux_mux.neg <= MUX_LAST_AIN);
  end

  // read data comes from next values, so a read right after a write sees it
  always_comb begin
    nxt_rdata = '0;
    if (take && !HWRITE && addr_ok) begin
      unique case (addr_idx)
        IDX_PIN_DIR: begin
          nxt_rdata[NUM_PINS-1:0] = nxt_pin_dir;
        end
        IDX_PIN_DATA: begin
          nxt_rdata[NUM_PINS-1:0] = pin_read_bits;
        end
        IDX_AUX_CFG: begin
          nxt_rdata[REG_W-1:0] = nxt_aux_cfg;
        end
        IDX_AUX_MUX: begin
          nxt_rdata[REG_W-1:0] = nxt_aux_mux;
        end
        IDX_AUX_STAT: begin
          nxt_rdata[REG_W-1:0] = stat_value;
        end
        default: begin
          nxt_rdata = '0;
        end
      endcase
    end
  end

  // zero wait states and no error answers: every data phase ends in one cycle
  always_comb begin
    nxt_readyout = 1'b1;
    nxt_resp     = HRESP_OKAY;
  end

  // ready stays low in reset so no transfer is taken before the registers settle
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      rdata_ff    <= '0;
      readyout_ff <= 1'b0;
      resp_ff     <= HRESP_OKAY;
    end else begin
      rdata_ff    <= nxt_rdata;
      readyout_ff <= nxt_readyout;
      resp_ff     <= nxt_resp;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign HREADYOUT        = readyout_ff;
  assign HRDATA           = rdata_ff;
  assign HRESP            = resp_ff;
  assign PIN_OUT          = pin_out_ff;
  assign PIN_OE           = pin_oe_ff;
  assign AUX_CFG          = aux_cfg_ff;
  assign AUX_INPUT_SEL    = aux_mux_ff;
  assign AUX_GAIN_FACTOR  = gain_factor_ff;
  assign AUX_REF_RESERVED = ref_rsvd_ff;

endmodule

//--- src/aux_rate_timer.sv
// sample-rate enable divider for the auxiliary converter
`timescale 1ns/1ps
module aux_rate_timer
  import aux_regs_pkg::*;
#(
  parameter int unsigned CNT_10  = DIV_10,
  parameter int unsigned CNT_100 = DIV_100,
  parameter int unsigned CNT_400 = DIV_400,
  parameter int unsigned CNT_800 = DIV_800
) (
  // clock and reset
  input  wire logic      clk,
  input  wire logic      resetn,
  // selected rate and one-cycle tick per sample period
  input  aux_rate_e      rate,
  output logic           tick
);

  logic [RATE_CNT_W-1:0] cnt_ff;
  logic [RATE_CNT_W-1:0] nxt_cnt;
  logic [RATE_CNT_W-1:0] last_cnt;
  aux_rate_e             rate_ff;
  logic                  tick_ff;
  logic                  nxt_tick;

  always_comb begin
    unique case (rate)
      RATE_10SPS:  last_cnt = RATE_CNT_W'(CNT_10 - 1);
      RATE_100SPS: last_cnt = RATE_CNT_W'(CNT_100 - 1);
      RATE_400SPS: last_cnt = RATE_CNT_W'(CNT_400 - 1);
      RATE_800SPS: last_cnt = RATE_CNT_W'(CNT_800 - 1);
    endcase
    nxt_tick = 1'b0;
    // a rate change restarts the period so no short period leaks out
    if (rate != rate_ff) begin
      nxt_cnt = '0;
    end else if (cnt_ff >= last_cnt) begin
      nxt_cnt  = '0;
      nxt_tick = 1'b1;
    end else begin
      nxt_cnt = cnt_ff + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      cnt_ff  <= '0;
      rate_ff <= RATE_10SPS;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      rate_ff <= rate;
      tick_ff <= nxt_tick;
    end
  end

  assign tick = tick_ff;

endmodule

//--- src/aux_regs_pkg.sv
// constants, field layouts and types shared by the pin data and auxiliary converter registers
package aux_regs_pkg;

  // widths
  localparam int NUM_PINS  = 8;
  localparam int REG_W     = 8;
  localparam int BUS_W     = 32;
  localparam int IDX_W     = 8;
  localparam int IDX_LSB   = 2;
  localparam int RATE_CNT_W = 23;

  // register indices; the byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_PIN_DIR   = 8'h13;
  localparam logic [IDX_W-1:0] IDX_PIN_DATA  = 8'h14;
  localparam logic [IDX_W-1:0] IDX_AUX_CFG   = 8'h15;
  localparam logic [IDX_W-1:0] IDX_AUX_MUX   = 8'h16;
  localparam logic [IDX_W-1:0] IDX_AUX_STAT  = 8'h20;

  // reset values
  localparam logic [REG_W-1:0] RST_PIN_DIR   = 8'h00;
  localparam logic [REG_W-1:0] RST_PIN_DATA  = 8'h00;
  localparam logic [REG_W-1:0] RST_AUX_CFG   = 8'h00;
  localparam logic [REG_W-1:0] RST_AUX_MUX   = 8'h01;

  // direction bit meaning
  localparam logic DIR_OUTPUT = 1'b0;
  localparam logic DIR_INPUT  = 1'b1;

  // auxiliary conversion rates
  typedef enum logic [1:0] {
    RATE_10SPS  = 2'h0,
    RATE_100SPS = 2'h1,
    RATE_400SPS = 2'h2,
    RATE_800SPS = 2'h3
  } aux_rate_e;

  // auxiliary reference pairs; codes above supply rails are reserved
  localparam logic [2:0] REF_INTERNAL = 3'h0;
  localparam logic [2:0] REF_AIN01    = 3'h1;
  localparam logic [2:0] REF_AIN23    = 3'h2;
  localparam logic [2:0] REF_AIN45    = 3'h3;
  localparam logic [2:0] REF_SUPPLY   = 3'h4;

  // input select codes
  localparam logic [3:0] MUX_LAST_AIN = 4'h9;
  localparam logic [3:0] MUX_COMMON   = 4'hA;

  // status register bit positions
  localparam int STAT_REF_RSVD   = 0;
  localparam int STAT_POS_COMMON = 1;
  localparam int STAT_NEG_COMMON = 2;
  localparam int STAT_POS_AIN    = 3;
  localparam int STAT_NEG_AIN    = 4;

  typedef struct packed {
    aux_rate_e  rate;
    logic [2:0] ref_sel;
    logic [2:0] gain;
  } aux_cfg_s;

  typedef struct packed {
    logic [3:0] pos;
    logic [3:0] neg;
  } aux_mux_s;

  // ahb-lite encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'b0;

  // timing
  localparam int unsigned CLK_HZ       = 50_000_000;
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned SPS_10  = 10;
  localparam int unsigned SPS_100 = 100;
  localparam int unsigned SPS_400 = 400;
  localparam int unsigned SPS_800 = 800;
  localparam int unsigned DIV_10  = CLK_HZ / SPS_10;
  localparam int unsigned DIV_100 = CLK_HZ / SPS_100;
  localparam int unsigned DIV_400 = CLK_HZ / SPS_400;
  localparam int unsigned DIV_800 = CLK_HZ / SPS_800;

endpackage

//--- src/pin_level_sync.sv
// two-stage synchroniser for the general-purpose pin levels
`timescale 1ns/1ps
module pin_level_sync #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             resetn,
  // asynchronous levels in, synchronised levels out
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic meta_ff;
      logic stable_ff;
      // first stage feeds only the second stage
      always_ff @(posedge clk) begin
        if (!resetn) begin
          meta_ff   <= 1'b0;
          stable_ff <= 1'b0;
        end else begin
          meta_ff   <= async_in[i];
          stable_ff <= meta_ff;
        end
      end
      assign sync_out[i] = stable_ff;
    end
  endgenerate

endmodule

//--- test/aux_pin_regs_props.sv
// bound checker for the pin data and auxiliary converter registers
`timescale 1ns/1ps
module aux_pin_regs_chk
  import aux_regs_pkg::*;
#(
  parameter int unsigned CNT_10  = DIV_10,
  parameter int unsigned CNT_100 = DIV_100,
  parameter int unsigned CNT_400 = DIV_400,
  parameter int unsigned CNT_800 = DIV_800
) (
  // clock and reset
  input wire logic                 CLK,
  input wire logic                 RESETN,
  // bus
  input wire logic                 HSEL,
  input wire logic [BUS_W-1:0]     HADDR,
  input wire logic [1:0]           HTRANS,
  input wire logic                 HWRITE,
  input wire logic [2:0]           HSIZE,
  input wire logic [BUS_W-1:0]     HWDATA,
  input wire logic                 HREADY,
  input wire logic                 HREADYOUT,
  input wire logic [BUS_W-1:0]     HRDATA,
  input wire logic                 HRESP,
  // pins and converter controls
  input wire logic [NUM_PINS-1:0]  PIN_IN,
  input wire logic [NUM_PINS-1:0]  PIN_OUT,
  input wire logic [NUM_PINS-1:0]  PIN_OE,
  input aux_regs_pkg::aux_cfg_s    AUX_CFG,
  input aux_regs_pkg::aux_mux_s    AUX_INPUT_SEL,
  input wire logic [REG_W-1:0]     AUX_GAIN_FACTOR,
  input wire logic                 AUX_REF_RESERVED,
  input wire logic                 AUX_SAMPLE_TICK
);
  default clocking dc @(posedge CLK); endclocking
  default disable iff (!RESETN);
  logic [IDX_W-1:0] idx;
  logic             req;
  assign idx = HADDR[9:2];
  assign req = HSEL && HTRANS == HTRANS_NONSEQ && HREADY;

  AST_RESET_VALUES: assert property ($rose(RESETN) |-> AUX_CFG == RST_AUX_CFG &&
    AUX_INPUT_SEL == RST_AUX_MUX && PIN_OUT == RST_PIN_DATA) else $error("reset values wrong");
  AST_OE_AFTER_RESET: assert property ($rose(RESETN) |=> PIN_OE == 8'hFF)
    else $error("pins not outputs after reset");
  AST_CFG_WRITE: assert property (req && HWRITE && HADDR == {22'h0, IDX_AUX_CFG, 2'h0}
    |=> ##1 AUX_CFG == $past(HWDATA[7:0])) else $error("config write lost");
  AST_MUX_WRITE: assert property (req && HWRITE && HADDR == {22'h0, IDX_AUX_MUX, 2'h0}
    |=> ##1 AUX_INPUT_SEL == $past(HWDATA[7:0])) else $error("input select write lost");
  AST_DATA_WRITE: assert property (req && HWRITE && HADDR == {22'h0, IDX_PIN_DATA, 2'h0}
    |=> ##1 PIN_OUT == $past(HWDATA[7:0])) else $error("pin data write lost");
  AST_OUT_READ: assert property (req && !HWRITE && HADDR == {22'h0, IDX_PIN_DATA, 2'h0}
    |=> ((HRDATA[7:0] ^ PIN_OUT) & PIN_OE) == 8'h00) else $error("output pin read wrong");
  AST_GAIN_POW2: assert property (AUX_GAIN_FACTOR == (8'h01 << AUX_CFG.gain))
    else $error("gain factor wrong");
  AST_REF_FLAG: assert property (AUX_REF_RESERVED == (AUX_CFG.ref_sel > REF_SUPPLY))
    else $error("reserved reference flag wrong");
  AST_BUS_IDLE: assert property ($past(RESETN) |-> HREADYOUT && HRESP == HRESP_OKAY &&
    HRDATA[31:8] == 24'h0) else $error("bus response wrong");
  AST_TICK_SPACING: assert property (AUX_SAMPLE_TICK |=> !AUX_SAMPLE_TICK [*4])
    else $error("ticks too close");
  AST_UNMAPPED_READ: assert property (req && !HWRITE && (HADDR[1:0] != 2'h0 ||
    idx > IDX_AUX_STAT || idx < IDX_PIN_DIR) |=> HRDATA == 32'h0) else $error("unmapped read");
endmodule

bind aux_pin_regs aux_pin_regs_chk #(.CNT_10(CNT_10), .CNT_100(CNT_100), .CNT_400(CNT_400),
  .CNT_800(CNT_800)) chk (.*);

//--- test/aux_pin_regs_tb.sv
// self-checking bench for the pin data and auxiliary converter registers
`timescale 1ns/1ps
module aux_pin_regs_tb;
  import aux_regs_pkg::*;
  localparam int unsigned CNT[4] = '{40, 20, 10, 5};
  logic clk, resetn, hsel, hwrite, hreadyout, hresp, ref_rsvd, tick;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata;
  logic [7:0]  pin_in, pin_out, pin_oe, gain_f;
  aux_cfg_s    aux_cfg;
  aux_mux_s    aux_sel;
  int          fails, compares;

  aux_pin_regs #(.CNT_10(CNT[0]), .CNT_100(CNT[1]), .CNT_400(CNT[2]), .CNT_800(CNT[3])) dut (
    .CLK(clk), .RESETN(resetn), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout), .HREADYOUT(hreadyout), .HRDATA(hrdata),
    .HRESP(hresp), .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe), .AUX_CFG(aux_cfg),
    .AUX_INPUT_SEL(aux_sel), .AUX_GAIN_FACTOR(gain_f), .AUX_REF_RESERVED(ref_rsvd),
    .AUX_SAMPLE_TICK(tick));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  // ready and read data are taken at the rising edge, before the flops move
  task automatic wait_rdy(output logic [31:0] rd);
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask

  task automatic bus(input logic [31:0] a, input logic w, input logic [7:0] wd,
                     output logic [31:0] rd);
    logic [31:0] d;
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    wait_rdy(d);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    wait_rdy(rd);
  endtask

  function automatic logic [31:0] ra(input logic [IDX_W-1:0] i);
    return {22'h0, i, 2'h0};
  endfunction

  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    logic [31:0] r;
    bus(a, 1'b1, d, r);
  endtask

  task automatic rdc(input logic [31:0] a, input logic [7:0] e);
    logic [31:0] r;
    bus(a, 1'b0, 8'h00, r);
    chk({24'h0, e}, r);
  endtask

  task automatic t_reset();
    // drivers turn on at the first edge after release; look one edge later
    @(posedge clk);
    chk({24'h0, RST_AUX_CFG}, {24'h0, aux_cfg});
    chk(32'hFF, {24'h0, pin_oe});
    chk(32'h01, {24'h0, gain_f});
    rdc(ra(IDX_AUX_CFG), RST_AUX_CFG);
    rdc(ra(IDX_AUX_MUX), RST_AUX_MUX);
    rdc(ra(IDX_PIN_DATA), RST_PIN_DATA);
    rdc(ra(IDX_PIN_DIR), RST_PIN_DIR);
    $display("reset values checked");
  endtask

  task automatic t_cfg();
    logic [7:0] v;
    int n;
    for (int i = 0; i < 8; i++) begin
      v = {i[1:0], i[2:0], i[2:0]};
      wr(ra(IDX_AUX_CFG), v);
      rdc(ra(IDX_AUX_CFG), v);
      chk({24'h0, v}, {24'h0, aux_cfg});
      chk(32'h1 << i, {24'h0, gain_f});
      chk({31'h0, i > 4}, {31'h0, ref_rsvd});
      @(posedge clk);
      while (tick !== 1'b1) @(posedge clk);
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (tick !== 1'b1 && n < 100);
      chk(CNT[i % 4], n);
    end
    $display("config fields checked");
  endtask

  task automatic t_mux();
    logic [7:0] v;
    for (int i = 0; i <= 10; i++) begin
      v = {i[3:0], MUX_COMMON - i[3:0]};
      wr(ra(IDX_AUX_MUX), v);
      rdc(ra(IDX_AUX_MUX), v);
      chk({24'h0, v}, {24'h0, aux_sel});
      rdc(ra(IDX_AUX_STAT), {3'h0, i >= 1, i <= 9, i == 0, i == 10, 1'b1});
    end
    $display("input select checked");
  endtask

  task automatic t_pins();
    pin_in <= 8'hA5;
    wr(ra(IDX_PIN_DIR), 8'h0F);
    wr(ra(IDX_PIN_DATA), 8'h3C);
    // the pins move on the edge that ends the write
    @(posedge clk);
    chk(32'hF0, {24'h0, pin_oe});
    chk(32'h3C, {24'h0, pin_out});
    rdc(ra(IDX_PIN_DATA), 8'h35);
    pin_in <= 8'h5A;
    repeat (3) @(posedge clk);
    rdc(ra(IDX_PIN_DATA), 8'h3A);
    wr(ra(IDX_PIN_DIR), 8'h00);
    rdc(ra(IDX_PIN_DATA), 8'h3C);
    $display("pin data checked");
  endtask

  task automatic t_refuse();
    wr(ra(IDX_AUX_CFG), 8'h5A);
    wr(ra(IDX_AUX_CFG) | 32'h2, 8'hFF);
    wr(ra(8'h30), 8'hFF);
    wr(ra(IDX_AUX_STAT), 8'hFF);
    rdc(ra(IDX_AUX_CFG), 8'h5A);
    rdc(ra(8'h30), 8'h00);
    rdc(ra(IDX_PIN_DATA) | 32'h1, 8'h00);
    chk({31'h0, HRESP_OKAY}, {31'h0, hresp});
    $display("refusals checked");
  endtask

  task automatic close_out();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    {resetn, hsel, hwrite, htrans, haddr, hwdata, pin_in} = '0;
    hsize = 3'h2;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    t_reset();
    t_cfg();
    t_mux();
    t_pins();
    t_refuse();
    resetn <= 1'b0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    t_reset();
    close_out();
  end

  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    close_out();
  end
endmodule
